// ---- rtl/watch_timer_pkg.sv ----
// Package for the watch and interval timer: register layout, reset values, counts.
// Assumes a single 10 MHz clock and a plain strobe register port.
package watch_timer_pkg;

  localparam int unsigned  CLK_PERIOD_NS    = 100;
  localparam logic [1:0]   ADDR_MODE        = 2'h0;
  localparam logic [1:0]   ADDR_STATUS      = 2'h1;
  localparam logic [1:0]   ADDR_MASK        = 2'h2;
  localparam logic [7:0]   MODE_RESET       = 8'h00;
  localparam logic [1:0]   IRQ_RESET        = 2'h0;
  localparam int unsigned  OP_ENABLE_POS    = 0;
  localparam int unsigned  COUNTER_START_POS = 1;
  localparam int unsigned  WATCH_SEL_LSB    = 2;
  localparam int unsigned  INTERVAL_SEL_LSB = 4;
  localparam int unsigned  CLOCK_SRC_POS    = 7;
  localparam int unsigned  WATCH_IRQ_POS    = 0;
  localparam int unsigned  INTERVAL_IRQ_POS = 1;
  localparam int unsigned  PRS_DIV_LOG2     = 7;
  localparam int unsigned  PRESCALER_W      = 11;
  localparam int unsigned  COUNTER_W        = 5;
  localparam int unsigned  FWX_TAP_W        = 9;
  localparam int unsigned  INTERVAL_BASE    = 3;
  localparam int unsigned  FAST_TAP_LOW     = 3;
  localparam int unsigned  FAST_TAP_HIGH    = 4;

endpackage : watch_timer_pkg

// ---- rtl/watch_timer.sv ----
// Watch timer with interval timer: prescaler, 5-bit counter, mode/status/mask registers.
// Assumes subsystem clock arrives asynchronously on a pin; all logic on clk.
//
// Strobed register access and the register addresses were left to the implementer.
module watch_timer
  import watch_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       subClk,
  output logic            watchIrq,
  output logic            intervalIrq,
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]             watchMode_r;
  logic [1:0]             status_r;
  logic [1:0]             mask_r;
  logic [PRS_DIV_LOG2-1:0] prsDiv_r;
  logic [2:0]             subSync_r;
  logic [PRESCALER_W-1:0] prescaler_r;
  logic [COUNTER_W-1:0]   counter_r;
  logic                   startPrev_r;
  logic                   watchIrq_r;
  logic                   intervalIrq_r;

  logic opEnable;
  logic counterStart;
  logic clockSourceSel;
  logic [1:0] watchPeriodSel;
  logic [2:0] intervalSel;
  logic wTick;
  logic watchRun;
  logic fwxTick;
  logic intervalHit;
  logic watchHit;
  logic [PRESCALER_W-1:0] prescalerNext;

  assign opEnable       = watchMode_r[OP_ENABLE_POS];
  assign counterStart   = watchMode_r[COUNTER_START_POS];
  assign clockSourceSel = watchMode_r[CLOCK_SRC_POS];
  assign watchPeriodSel = watchMode_r[WATCH_SEL_LSB +: 2];
  assign intervalSel    = watchMode_r[INTERVAL_SEL_LSB +: 3];
  assign watchRun       = opEnable & counterStart;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      watchMode_r <= MODE_RESET;
    end else if (wr && addr == ADDR_MODE) begin
      watchMode_r <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watch clock source

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prsDiv_r <= '0;
    end else begin
      prsDiv_r <= prsDiv_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      subSync_r <= 3'h0;
    end else begin
      subSync_r <= {subSync_r[1:0], subClk};
    end
  end

  always_comb begin
    if (clockSourceSel) begin
      wTick = subSync_r[1] & ~subSync_r[2];
    end else begin
      wTick = &prsDiv_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and interval tap

  assign prescalerNext = prescaler_r + 1'b1;

  always_ff @(posedge clk) begin
    if (!rstn || !opEnable) begin
      prescaler_r <= '0;
    end else if (wTick) begin
      prescaler_r <= prescalerNext;
    end
  end

  always_comb begin
    intervalHit = wTick & opEnable &
                  (prescalerNext[INTERVAL_BASE + intervalSel] &
                   ~prescaler_r[INTERVAL_BASE + intervalSel]);
    fwxTick = wTick & opEnable & (&prescaler_r[FWX_TAP_W-1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watch counter

  always_ff @(posedge clk) begin
    if (!rstn) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= watchRun;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !watchRun) begin
      counter_r <= '0;
    end else if (fwxTick) begin
      counter_r <= counter_r + 1'b1;
    end
  end

  always_comb begin
    case (watchPeriodSel)
      2'h0: watchHit = fwxTick & (&counter_r);
      2'h1: watchHit = fwxTick & (&counter_r[COUNTER_W-2:0]);
      2'h2: watchHit = wTick & prescalerNext[FAST_TAP_HIGH] &
                       ~prescaler_r[FAST_TAP_HIGH];
      2'h3: watchHit = wTick & prescalerNext[FAST_TAP_LOW] &
                       ~prescaler_r[FAST_TAP_LOW];
      default: watchHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      watchIrq_r    <= 1'b0;
      intervalIrq_r <= 1'b0;
    end else begin
      watchIrq_r    <= watchHit & watchRun & startPrev_r;
      intervalIrq_r <= intervalHit;
    end
  end

  assign watchIrq    = watchIrq_r;
  assign intervalIrq = intervalIrq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_r <= IRQ_RESET;
    end else begin
      status_r <= (status_r & ~((wr && addr == ADDR_STATUS) ? wdata[1:0] : 2'h0))
                  | {intervalIrq_r, watchIrq_r};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_r <= IRQ_RESET;
    end else if (wr && addr == ADDR_MASK) begin
      mask_r <= wdata[1:0];
    end
  end

  assign irq = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        ADDR_MODE:   rdata <= watchMode_r;
        ADDR_STATUS: rdata <= {6'h00, status_r};
        ADDR_MASK:   rdata <= {6'h00, mask_r};
        default:     rdata <= {3'h0, counter_r};
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : watch_timer

// ---- sim/watch_timer_monitor.sv ----
// Port checker for the watch timer.
// Assumes binding to every watch_timer instance.
module watch_timer_monitor
  import watch_timer_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       subClk,
  input wire logic       watchIrq,
  input wire logic       intervalIrq,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic modeWr;
  assign modeWr = wr && addr == ADDR_MODE;
  ////////////////////////////////////////////////////////////////
  a_watch_pulse: assert property (watchIrq |=> !watchIrq) else $error("watch pulse long");
  a_intv_pulse: assert property (intervalIrq |=> !intervalIrq) else $error("interval pulse long");
  a_reset_quiet: assert property ($rose(rstn) |-> !watchIrq && !intervalIrq) else $error("pulse at reset");
  a_reset_irq: assert property ($rose(rstn) |-> !irq ##1 !irq) else $error("irq at reset");
  a_intv_stop: assert property (modeWr && !wdata[0] |-> ##3 !intervalIrq [*8])
    else $error("interval runs when stopped");
  a_watch_stop: assert property (modeWr && wdata[1:0] != 2'h3 |-> ##3 !watchIrq [*8])
    else $error("watch runs when stopped");
  a_mode_back: assert property (modeWr ##2 (rd && addr == ADDR_MODE) |=> rdata == $past(wdata, 3))
    else $error("mode readback");
  a_count_clear: assert property ((modeWr && !wdata[1]) ##2 (rd && addr == 2'h3) |=> rdata == 8'h00)
    else $error("counter not cleared");
  c_watch: cover property (watchIrq);
  c_intv: cover property (intervalIrq);
  c_irq: cover property (irq);
endmodule : watch_timer_monitor

bind watch_timer watch_timer_monitor u_mon (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .subClk(subClk), .watchIrq(watchIrq), .intervalIrq(intervalIrq), .irq(irq));

// ---- sim/watch_and_interval_timer_tb.sv ----
// Bench for watch_timer: register rows, periods, stop, interrupts.
// Assumes a subsystem clock of four clk periods made here.
module watch_and_interval_timer_tb import watch_timer_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, subClk = 1'b0;
  logic       watchIrq, intervalIrq, irq;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  int         bad_count, checked, cyc, n;
  logic [7:0] rows [4][3] = '{'{8'h00, 8'h5c, 8'h5c}, '{8'h02, 8'h03, 8'h03}, '{8'h03, 8'hff, 8'h00},
                              '{8'h00, 8'h00, 8'h00}};
  watch_timer DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .subClk(subClk), .watchIrq(watchIrq), .intervalIrq(intervalIrq), .irq(irq));
  always #50 clk = ~clk;
  always #200 subClk = ~subClk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) d = rdata;
  endtask : rreg
  task automatic per(input logic w, output int c);
    c = 1;
    while ((w ? watchIrq : intervalIrq) !== 1'b1) @(posedge clk);
    @(posedge clk);
    while ((w ? watchIrq : intervalIrq) !== 1'b1) begin
      @(posedge clk);
      c++;
    end
  endtask : per
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(ADDR_MODE, v);
    cmp("mode", MODE_RESET, v);
    for (int i = 0; i < 4; i++) begin
      wreg(rows[i][0][1:0], rows[i][1]);
      rreg(rows[i][0][1:0], v);
      cmp("reg", rows[i][2], v);
    end
    for (int c = 0; c < 8; c++) begin
      wreg(ADDR_MODE, 8'h81 | 8'(c << 4));
      per(1'b0, n);
      cmp("interval", 16'(64 << c), 16'(n));
      wreg(ADDR_MODE, 8'h00);
    end
    for (int c = 2; c < 4; c++) begin
      wreg(ADDR_MODE, 8'h83 | 8'(c << 2));
      per(1'b1, n);
      per(1'b1, n);
      cmp("watch", 16'(512 >> c), 16'(n));
    end
    wreg(ADDR_MODE, 8'h83);
    rreg(2'h3, v);
    n = v;
    repeat (4093) @(posedge clk);
    rreg(2'h3, v);
    cmp("counter", 16'((n + 2) % 32), 16'(v));
    wreg(ADDR_MODE, 8'h8d);
    rreg(2'h3, v);
    cmp("count", 8'h00, v);
    per(1'b0, n);
    cmp("interval", 16'd64, 16'(n));
    wreg(ADDR_MODE, 8'h00);
    wreg(ADDR_MODE, 8'h01);
    per(1'b0, n);
    cmp("interval", 16'd2048, 16'(n));
    wreg(ADDR_MODE, 8'h00);
    rreg(ADDR_STATUS, v);
    cmp("status", 2'h3, v[1:0]);
    cmp("irq", 1'b1, irq);
    wreg(ADDR_MASK, 8'h01);
    wreg(ADDR_STATUS, 8'h01);
    @(posedge clk);
    cmp("irq", 1'b0, irq);
    rreg(ADDR_STATUS, v);
    cmp("status", 2'h2, v[1:0]);
    wreg(ADDR_MODE, 8'h81);
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(ADDR_MODE, v);
    cmp("mode", MODE_RESET, v);
    cmp("irq", 1'b0, irq);
    summarize();
  end
endmodule : watch_and_interval_timer_tb
